// ### ucesel_pkg.sv
// Package: event codes, unit masks and counter constants for the uncore event selector
package ucesel_pkg;
  localparam int EVT_W = 8;
  localparam int UMASK_W = 8;
  localparam int CNT_W_DEF = 48;
  localparam int INC_W = 3;

  // Event numbers
  localparam logic [7:0] EVT_LINE_ALLOC = 8'h0a;
  localparam logic [7:0] EVT_LINE_VICTIM = 8'h0b;
  localparam logic [7:0] EVT_HOME_REQ = 8'h20;
  localparam logic [7:0] EVT_TRK_FULL = 8'h21;
  localparam logic [7:0] EVT_TRK_BUSY = 8'h22;

  // Unit masks, line allocation
  localparam logic [7:0] UM_ALLOC_M = 8'h01;
  localparam logic [7:0] UM_ALLOC_E = 8'h02;
  localparam logic [7:0] UM_ALLOC_S = 8'h04;
  localparam logic [7:0] UM_ALLOC_F = 8'h08;
  localparam logic [7:0] UM_ALLOC_ANY = 8'h0f;

  // Unit masks, line victimisation
  localparam logic [7:0] UM_VICT_M = 8'h01;
  localparam logic [7:0] UM_VICT_E = 8'h02;
  localparam logic [7:0] UM_VICT_S = 8'h04;
  localparam logic [7:0] UM_VICT_I = 8'h08;
  localparam logic [7:0] UM_VICT_F = 8'h10;
  localparam logic [7:0] UM_VICT_ANY = 8'h1f;

  // Unit masks, home agent requests
  localparam logic [7:0] UM_REQ_IO_RD = 8'h01;
  localparam logic [7:0] UM_REQ_IO_WR = 8'h02;
  localparam logic [7:0] UM_REQ_REM_RD = 8'h04;
  localparam logic [7:0] UM_REQ_REM_WR = 8'h08;
  localparam logic [7:0] UM_REQ_LOC_RD = 8'h10;
  localparam logic [7:0] UM_REQ_LOC_WR = 8'h20;

  // Unit masks, tracker selection
  localparam logic [7:0] UM_TRK_IO = 8'h01;
  localparam logic [7:0] UM_TRK_REM = 8'h02;
  localparam logic [7:0] UM_TRK_LOC = 8'h04;

  localparam logic [47:0] CNT_RESET = 48'h0;

  typedef enum logic [1:0] {
    UCESEL_IDLE = 2'b00,
    UCESEL_RUN = 2'b01
  } ucesel_state_t;
endpackage

// ### ucesel_popcnt.sv
// Population count of a small pulse vector
`timescale 1ns/1ps
`default_nettype none
module ucesel_popcnt #(
  parameter int N = 4,
  parameter int W = 3
) (
  input wire logic [N-1:0] bits_i,  // Event pulses
  output logic [W-1:0] count_o      // Number of set bits
);
  always_comb begin
    count_o = '0;
    for (int k = 0; k < N; k++) begin
      count_o = count_o + W'(bits_i[k]);
    end
  end
endmodule
`default_nettype wire

// ### ucesel_accum.sv
// Counter accumulator with clear
`timescale 1ns/1ps
`default_nettype none
module ucesel_accum #(
  parameter int CNT_W = 48,
  parameter int INC_W = 3
) (
  input wire logic clk_sys_i,            // Uncore clock
  input wire logic reset_i,              // Sync reset, active high
  input wire logic clear_i,              // Zero the count
  input wire logic enable_i,             // Counting allowed
  input wire logic [INC_W-1:0] inc_i,    // Amount to add this cycle
  output logic [CNT_W-1:0] count_o,      // Running count
  output logic wrap_o                    // Pulse when count wraps
);
  import ucesel_pkg::*;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W:0] sum;
  logic wrap_reg;

  assign sum = {1'b0, count_reg} + {{(CNT_W + 1 - INC_W){1'b0}}, inc_i};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || clear_i) begin
      count_reg <= CNT_RESET[CNT_W-1:0];
      wrap_reg <= 1'b0;
    end else begin
      count_reg <= enable_i ? sum[CNT_W-1:0] : count_reg;
      wrap_reg <= enable_i & sum[CNT_W];
    end
  end

  assign count_o = count_reg;
  assign wrap_o = wrap_reg;
endmodule
`default_nettype wire

// ### ucesel_top.sv
// Uncore cache and home agent event selector and counter
`timescale 1ns/1ps
`default_nettype none
module ucesel_top #(
  parameter int CNT_W = ucesel_pkg::CNT_W_DEF
) (
  input wire logic clk_sys_i,                          // Uncore clock, 100 MHz
  input wire logic reset_i,                            // Sync reset, active high
  input wire logic enable_i,                           // Counting enabled
  input wire logic clear_i,                            // Zero the counter
  input wire logic [ucesel_pkg::EVT_W-1:0] event_sel_i,   // Event number
  input wire logic [ucesel_pkg::UMASK_W-1:0] umask_sel_i, // Unit mask
  input wire logic alloc_m_i,                          // Line allocated modified
  input wire logic alloc_e_i,                          // Line allocated exclusive
  input wire logic alloc_s_i,                          // Line allocated shared
  input wire logic alloc_f_i,                          // Line allocated forward
  input wire logic victim_m_i,                         // Modified line victimised
  input wire logic victim_e_i,                         // Exclusive line victimised
  input wire logic victim_s_i,                         // Shared line victimised
  input wire logic victim_i_i,                         // Invalid line victimised
  input wire logic victim_f_i,                         // Forward line victimised
  input wire logic req_io_hub_rd_i,                    // Home read from io hub
  input wire logic req_io_hub_wr_i,                    // Home write from io hub
  input wire logic req_remote_rd_i,                    // Home read from remote socket
  input wire logic req_remote_wr_i,                    // Home write from remote socket
  input wire logic req_local_rd_i,                     // Home read from local socket
  input wire logic req_local_wr_i,                     // Home write from local socket
  input wire logic trk_io_hub_full_i,                  // io hub tracker all full
  input wire logic trk_remote_full_i,                  // Remote tracker all full
  input wire logic trk_local_full_i,                   // Local tracker all full
  input wire logic trk_io_hub_busy_i,                  // io hub tracker busy
  input wire logic trk_remote_busy_i,                  // Remote tracker busy
  input wire logic trk_local_busy_i,                   // Local tracker busy
  output logic [CNT_W-1:0] count_o,                    // Event count
  output logic wrap_o,                                 // Counter wrapped, one cycle
  output logic sel_valid_o,                            // Selection is a listed one
  output logic running_o                               // Counting active
);
  import ucesel_pkg::*;

  ucesel_state_t state_reg;
  ucesel_state_t state_next;

  // Event group decode
  wire is_alloc = (event_sel_i == EVT_LINE_ALLOC);
  wire is_victim = (event_sel_i == EVT_LINE_VICTIM);
  wire is_req = (event_sel_i == EVT_HOME_REQ);
  wire is_full = (event_sel_i == EVT_TRK_FULL);
  wire is_busy = (event_sel_i == EVT_TRK_BUSY);

  wire sel_alloc_m = is_alloc && (umask_sel_i == UM_ALLOC_M);
  wire sel_alloc_e = is_alloc && (umask_sel_i == UM_ALLOC_E);
  wire sel_alloc_s = is_alloc && (umask_sel_i == UM_ALLOC_S);
  wire sel_alloc_f = is_alloc && (umask_sel_i == UM_ALLOC_F);
  wire sel_alloc_any = is_alloc && (umask_sel_i == UM_ALLOC_ANY);

  wire sel_vict_m = is_victim && (umask_sel_i == UM_VICT_M);
  wire sel_vict_e = is_victim && (umask_sel_i == UM_VICT_E);
  wire sel_vict_s = is_victim && (umask_sel_i == UM_VICT_S);
  wire sel_vict_i = is_victim && (umask_sel_i == UM_VICT_I);
  wire sel_vict_f = is_victim && (umask_sel_i == UM_VICT_F);
  wire sel_vict_any = is_victim && (umask_sel_i == UM_VICT_ANY);

  wire sel_req_io_rd = is_req && (umask_sel_i == UM_REQ_IO_RD);
  wire sel_req_io_wr = is_req && (umask_sel_i == UM_REQ_IO_WR);
  wire sel_req_rem_rd = is_req && (umask_sel_i == UM_REQ_REM_RD);
  wire sel_req_rem_wr = is_req && (umask_sel_i == UM_REQ_REM_WR);
  wire sel_req_loc_rd = is_req && (umask_sel_i == UM_REQ_LOC_RD);
  wire sel_req_loc_wr = is_req && (umask_sel_i == UM_REQ_LOC_WR);

  wire sel_full_io = is_full && (umask_sel_i == UM_TRK_IO);
  wire sel_full_rem = is_full && (umask_sel_i == UM_TRK_REM);
  wire sel_full_loc = is_full && (umask_sel_i == UM_TRK_LOC);
  wire sel_busy_io = is_busy && (umask_sel_i == UM_TRK_IO);
  wire sel_busy_rem = is_busy && (umask_sel_i == UM_TRK_REM);
  wire sel_busy_loc = is_busy && (umask_sel_i == UM_TRK_LOC);

  wire listed = sel_alloc_m | sel_alloc_e | sel_alloc_s | sel_alloc_f | sel_alloc_any
              | sel_vict_m | sel_vict_e | sel_vict_s | sel_vict_i | sel_vict_f | sel_vict_any
              | sel_req_io_rd | sel_req_io_wr | sel_req_rem_rd | sel_req_rem_wr
              | sel_req_loc_rd | sel_req_loc_wr
              | sel_full_io | sel_full_rem | sel_full_loc
              | sel_busy_io | sel_busy_rem | sel_busy_loc;

  // Qualified pulses: the any-state masks may see several events per cycle
  wire [3:0] alloc_q = {
    alloc_f_i & (sel_alloc_f | sel_alloc_any),
    alloc_s_i & (sel_alloc_s | sel_alloc_any),
    alloc_e_i & (sel_alloc_e | sel_alloc_any),
    alloc_m_i & (sel_alloc_m | sel_alloc_any)
  };
  wire [4:0] vict_q = {
    victim_f_i & (sel_vict_f | sel_vict_any),
    victim_i_i & (sel_vict_i | sel_vict_any),
    victim_s_i & (sel_vict_s | sel_vict_any),
    victim_e_i & (sel_vict_e | sel_vict_any),
    victim_m_i & (sel_vict_m | sel_vict_any)
  };
  wire single_q = (req_io_hub_rd_i & sel_req_io_rd) | (req_io_hub_wr_i & sel_req_io_wr)
                | (req_remote_rd_i & sel_req_rem_rd) | (req_remote_wr_i & sel_req_rem_wr)
                | (req_local_rd_i & sel_req_loc_rd) | (req_local_wr_i & sel_req_loc_wr)
                | (trk_io_hub_full_i & sel_full_io) | (trk_remote_full_i & sel_full_rem)
                | (trk_local_full_i & sel_full_loc)
                | (trk_io_hub_busy_i & sel_busy_io) | (trk_remote_busy_i & sel_busy_rem)
                | (trk_local_busy_i & sel_busy_loc);

  logic [INC_W-1:0] alloc_cnt;
  logic [INC_W-1:0] vict_cnt;

  ucesel_popcnt #(.N(4), .W(INC_W)) u_alloc_pop (
    .bits_i(alloc_q),
    .count_o(alloc_cnt)
  );

  ucesel_popcnt #(.N(5), .W(INC_W)) u_vict_pop (
    .bits_i(vict_q),
    .count_o(vict_cnt)
  );

  wire [INC_W-1:0] inc_amt = alloc_cnt | vict_cnt | {{(INC_W - 1){1'b0}}, single_q};

  // Run while enabled and not being cleared
  always_comb begin
    case (state_reg)
      UCESEL_IDLE: state_next = (enable_i && !clear_i) ? UCESEL_RUN : UCESEL_IDLE;
      UCESEL_RUN: state_next = (enable_i && !clear_i) ? UCESEL_RUN : UCESEL_IDLE;
      default: state_next = UCESEL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_reg <= UCESEL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Inputs registered once so the count is a clean flop path
  logic [INC_W-1:0] inc_reg;
  logic inc_en_reg;
  logic sel_valid_reg;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      inc_reg <= '0;
      inc_en_reg <= 1'b0;
      sel_valid_reg <= 1'b0;
    end else begin
      inc_reg <= listed ? inc_amt : '0;
      inc_en_reg <= enable_i && !clear_i;
      sel_valid_reg <= listed;
    end
  end

  ucesel_accum #(.CNT_W(CNT_W), .INC_W(INC_W)) u_accum (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .clear_i(clear_i),
    .enable_i(inc_en_reg),
    .inc_i(inc_reg),
    .count_o(count_o),
    .wrap_o(wrap_o)
  );

  assign sel_valid_o = sel_valid_reg;
  assign running_o = (state_reg == UCESEL_RUN);
endmodule
`default_nettype wire

// ### ucesel_src.sv
// Event source model standing in for the cache and home pipelines
`timescale 1ns/1ps
`default_nettype none
module ucesel_src (
  input wire logic clk_sys_i,    // Uncore clock
  input wire logic [20:0] req_i, // Events wanted next cycle
  output logic [20:0] ev_o       // Event pulses and tracker levels
);
  initial ev_o = '0;
  // Replays each request for as long as it is held, off the sampling edge
  always @(negedge clk_sys_i) begin
    ev_o <= req_i;
  end
endmodule
`default_nettype wire

// ### ucesel_chk.sv
// Port assertions for the event selector and counter
`timescale 1ns/1ps
`default_nettype none
module ucesel_chk
  import ucesel_pkg::*;
#(
  parameter int CNT_W = 48
) (
  input wire logic clk_sys_i,                          // Clock
  input wire logic reset_i,                            // Reset
  input wire logic enable_i,                           // Enable
  input wire logic clear_i,                            // Clear
  input wire logic [ucesel_pkg::EVT_W-1:0] event_sel_i,   // Event
  input wire logic [ucesel_pkg::UMASK_W-1:0] umask_sel_i, // Mask
  input wire logic alloc_m_i,                          // Alloc M
  input wire logic alloc_e_i,                          // Alloc E
  input wire logic alloc_s_i,                          // Alloc S
  input wire logic alloc_f_i,                          // Alloc F
  input wire logic trk_local_full_i,                   // Local full
  input wire logic [CNT_W-1:0] count_o,                // Count
  input wire logic wrap_o,                             // Wrap
  input wire logic sel_valid_o,                        // Listed
  input wire logic running_o                           // Running
);
  wire listed;
  wire all_alloc;
  assign listed = (event_sel_i == 8'h0a && umask_sel_i inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h0f}) ||
    (event_sel_i == 8'h0b && umask_sel_i inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h1f}) ||
    (event_sel_i == 8'h20 && umask_sel_i inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20}) ||
    ((event_sel_i == 8'h21 || event_sel_i == 8'h22) && umask_sel_i inside {8'h01, 8'h02, 8'h04});
  assign all_alloc = alloc_m_i && alloc_e_i && alloc_s_i && alloc_f_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  clear_zero_a: assert property (clear_i |=> count_o == '0)
    else $error("count not zero after clear");
  idle_hold_a: assert property ((!enable_i && !clear_i) ##1 !clear_i |=> $stable(count_o))
    else $error("count moved while disabled");
  unlisted_hold_a: assert property ((!listed && !clear_i) ##1 !clear_i |=> $stable(count_o))
    else $error("unlisted selection counted");
  sel_valid_a: assert property (1'b1 |=> sel_valid_o == $past(listed))
    else $error("selection valid flag wrong");
  run_state_a: assert property (1'b1 |=> running_o == $past(enable_i && !clear_i))
    else $error("running flag wrong");
  trk_add_a: assert property ((event_sel_i == 8'h21 && umask_sel_i == 8'h04 && trk_local_full_i && enable_i && !clear_i)
    ##1 !clear_i |=> count_o == CNT_W'($past(count_o) + 1))
    else $error("full cycle not added once");
  alloc_four_a: assert property ((event_sel_i == 8'h0a && umask_sel_i == 8'h0f && all_alloc && enable_i && !clear_i)
    ##1 !clear_i |=> count_o == CNT_W'($past(count_o) + 4))
    else $error("any-state allocations not summed");
  wrap_small_a: assert property (wrap_o |-> count_o < 10)
    else $error("wrap flagged at large count");
  cover property (trk_local_full_i && event_sel_i == 8'h21);
  cover property (all_alloc && umask_sel_i == 8'h0f);
  cover property (wrap_o);
endmodule
bind ucesel_top ucesel_chk #(.CNT_W(CNT_W)) i_ucesel_chk (.clk_sys_i, .reset_i, .enable_i, .clear_i, .event_sel_i,
  .umask_sel_i, .alloc_m_i, .alloc_e_i, .alloc_s_i, .alloc_f_i, .trk_local_full_i, .count_o, .wrap_o,
  .sel_valid_o, .running_o);
`default_nettype wire

// ### ucesel_tb_top.sv
// Self-checking testbench for the event selector and counter
`timescale 1ns/1ps
`default_nettype none
module ucesel_tb_top;
  import ucesel_pkg::*;
  localparam int CW = 6;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic enable_i = 1'b1;
  logic clear_i = 1'b0;
  logic [7:0] event_sel_i = 8'h00;
  logic [7:0] umask_sel_i = 8'h00;
  logic [20:0] req = '0;
  logic [20:0] ev;
  logic [CW-1:0] count_o;
  logic wrap_o;
  logic sel_valid_o;
  logic running_o;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] evs[5] = '{8'h0a, 8'h0b, 8'h20, 8'h21, 8'h22};
  int nk[5] = '{4, 5, 6, 3, 3};
  int base[5] = '{0, 4, 9, 15, 18};
  initial forever #5 clk_sys_i = ~clk_sys_i;
  ucesel_src i_ucesel_src (.clk_sys_i, .req_i(req), .ev_o(ev));
  ucesel_top #(.CNT_W(CW)) i_ucesel_top (.clk_sys_i, .reset_i, .enable_i, .clear_i, .event_sel_i, .umask_sel_i,
    .alloc_m_i(ev[0]), .alloc_e_i(ev[1]), .alloc_s_i(ev[2]), .alloc_f_i(ev[3]), .victim_m_i(ev[4]),
    .victim_e_i(ev[5]), .victim_s_i(ev[6]), .victim_i_i(ev[7]), .victim_f_i(ev[8]), .req_io_hub_rd_i(ev[9]),
    .req_io_hub_wr_i(ev[10]), .req_remote_rd_i(ev[11]), .req_remote_wr_i(ev[12]), .req_local_rd_i(ev[13]),
    .req_local_wr_i(ev[14]), .trk_io_hub_full_i(ev[15]), .trk_remote_full_i(ev[16]), .trk_local_full_i(ev[17]),
    .trk_io_hub_busy_i(ev[18]), .trk_remote_busy_i(ev[19]), .trk_local_busy_i(ev[20]), .count_o, .wrap_o,
    .sel_valid_o, .running_o);
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Clears, selects, fires v0 then every source, and judges the total
  task automatic measure(input logic [7:0] ev_c, input logic [7:0] um, input logic en, input logic [20:0] v0,
    input int exp, input logic vld);
    @(negedge clk_sys_i);
    event_sel_i <= ev_c;
    umask_sel_i <= um;
    enable_i <= en;
    clear_i <= 1'b1;
    @(negedge clk_sys_i);
    clear_i <= 1'b0;
    req <= v0;
    @(negedge clk_sys_i);
    req <= '1;
    @(negedge clk_sys_i);
    req <= '0;
    repeat (4) @(negedge clk_sys_i);
    chk("count", 48'(count_o), 48'(exp));
    chk("sel_valid", 48'(sel_valid_o), 48'(vld));
    chk("running", 48'(running_o), 48'(en));
    $display("test event %h mask %h done", ev_c, um);
  endtask
  // Holds a tracker full past the counter's range
  task automatic wrap_test;
    int seen;
    seen = 0;
    @(negedge clk_sys_i);
    event_sel_i <= 8'h21;
    umask_sel_i <= 8'h01;
    enable_i <= 1'b1;
    clear_i <= 1'b1;
    @(negedge clk_sys_i);
    clear_i <= 1'b0;
    req <= 21'h08000;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk_sys_i);
      if (i == 65) begin
        req <= '0;
      end
      if (wrap_o === 1'b1) begin
        seen++;
      end
    end
    chk("wrap", 48'(seen), 48'd1);
    chk("count", 48'(count_o), 48'((1 << CW) + 2 - (1 << CW)));
    $display("test wrap done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_sys_i);
    reset_i <= 1'b0;
    for (int e = 0; e < 5; e++) begin
      for (int k = 0; k < nk[e]; k++) begin
        measure(evs[e], 8'(1 << k), 1'b1, 21'(1 << (base[e] + k)), 2, 1'b1);
      end
    end
    measure(8'h0a, 8'h0f, 1'b1, 21'h0000f, 8, 1'b1);
    measure(8'h0b, 8'h1f, 1'b1, 21'h001f0, 10, 1'b1);
    measure(8'h0a, 8'h03, 1'b1, '1, 0, 1'b0);
    measure(8'h21, 8'h01, 1'b0, '1, 0, 1'b1);
    wrap_test();
    complete_run();
  end
endmodule
`default_nettype wire
